// ---- rtl/ufc_defs.svh ----
`ifndef UFC_DEFS_SVH
`define UFC_DEFS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define UFC_FRAME_CTRL_ADDR 8'ha9
`define UFC_DATA_BUF_ADDR   8'h99
`define UFC_FRAME_CTRL_RST  8'h0c

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define UFC_PAR_ODD   2'h0
`define UFC_PAR_EVEN  2'h1
`define UFC_PAR_MARK  2'h2
`define UFC_LEN_5     2'h0
`define UFC_LEN_8     2'h3
`define UFC_LEN_MIN   3'h4

// ----------------------------------------------------------------
// timing and sizes
// ----------------------------------------------------------------
`define UFC_CLK_HZ    50000000
`define UFC_BAUD_BPS  115200
`define UFC_HALF_CYC  (`UFC_CLK_HZ / (2 * `UFC_BAUD_BPS))
`define UFC_HALF_BIT  3'h2
`define UFC_HALF_1P5  3'h3
`define UFC_HALF_2    3'h4
`define UFC_FIFO_DEPTH 4
`define UFC_WORD_W    10

`endif

// ---- rtl/ufc_pkg.sv ----
package ufc_pkg;

	// same bit order as the frame control register
	typedef struct packed {
		logic       mce;
		logic [1:0] pkind;
		logic       pon;
		logic [1:0] wlen;
		logic       xon;
		logic       lstop;
	} ufc_cfg_s;

	typedef struct packed {
		logic       xbit;
		logic       perr;
		logic [7:0] data;
	} ufc_rx_word_s;

	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_XTRA, RX_STOP, RX_WAITHI
	} ufc_rx_state_e;

	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_XTRA, TX_STOP
	} ufc_tx_state_e;

endpackage

// ---- rtl/ufc_serial_port.sv ----
// Overview of operation
// - set receive flag when stop bit sampled high
// - flag clears only once receive FIFO empty
// - multiprocessor mode also needs extra bit one
// - parity enable adds, checks parity bit
// - length field 5..8 bits, resets to 8
// - extra bit enable appends software value
// - short stop lasts one bit time
// - long stop two bits, 1.5 at 5-bit
`timescale 1ns/1ps
`include "ufc_defs.svh"

// ----------------------------------------------------------------
// receive word fifo
// ----------------------------------------------------------------
module ufc_fifo #(
	parameter int WIDTH = `UFC_WORD_W,
	parameter int DEPTH = `UFC_FIFO_DEPTH
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic [WIDTH-1:0]      outData,
	input  wire logic             outReady
);
	// pointers wrap naturally, so depth must be a power of two
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wp;
		logic [PW-1:0]               rp;
		logic [CW-1:0]               cnt;
	} ufc_fifo_s;

	ufc_fifo_s s;
	ufc_fifo_s next_s;
	logic      push;
	logic      pop;

	assign inReady  = (s.cnt != CW'(DEPTH));
	assign outValid = (s.cnt != '0);
	assign outData  = s.mem[s.rp];

	always_comb begin
		next_s = s;
		push   = inValid && inReady;
		pop    = outValid && outReady;
		if (push) begin
			next_s.mem[s.wp] = inData;
			next_s.wp        = s.wp + PW'(1);
		end
		if (pop) begin
			next_s.rp = s.rp + PW'(1);
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + CW'(1);
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - CW'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// ----------------------------------------------------------------
// serial port with frame format control
// ----------------------------------------------------------------
module ufc_serial_port
	import ufc_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] sfrAddr,
	input  wire logic [7:0] sfrWrData,
	input  wire logic       sfrWr,
	input  wire logic       sfrRd,
	output logic [7:0]      sfrRdData,
	input  wire logic       rxDoneClear,
	input  wire logic       txExtraBit,
	input  wire logic       rxPin,
	output logic            txPin,
	output logic            txBusy,
	output logic            rxDoneFlag,
	output logic            rxExtraBit,
	output logic            parityError
);
	typedef struct packed {
		ufc_cfg_s      cfg;
		logic [7:0]    rdData;
		logic [2:0]    rxSync;
		logic          rxLevel;
		ufc_rx_state_e rxSt;
		logic [15:0]   rxCnt;
		logic [2:0]    rxHalf;
		logic [2:0]    rxIdx;
		logic [7:0]    rxShift;
		logic          rxPar;
		logic          rxXbit;
		ufc_rx_word_s  pend;
		logic          pendValid;
		logic          doneFlag;
		logic          parErr;
		logic          lastXbit;
		ufc_tx_state_e txSt;
		logic [15:0]   txCnt;
		logic [2:0]    txHalf;
		logic [2:0]    txIdx;
		logic [7:0]    txShift;
		logic          txXbit;
		logic          txLine;
		logic          txBusy;
	} ufc_state_s;

	localparam logic [15:0] HALF_LAST = 16'(`UFC_HALF_CYC - 1);

	ufc_state_s   s;
	ufc_state_s   next_s;
	ufc_rx_word_s headWord;
	logic         fifoInReady;
	logic         fifoOutValid;
	logic         popReq;
	logic         rxTick;
	logic         rxEvent;
	logic         txTick;
	logic         txEnd;
	logic         rxGood;
	logic         rxPerr;

	// ------------------------------------------------------------
	// decoding: length and parity shared by both directions, stop length transmit only
	// ------------------------------------------------------------
	function automatic logic [2:0] lastIdx(input logic [1:0] wlen);
		// index of the last data bit: code 0 ends at bit 4, code 3 at bit 7
		lastIdx = `UFC_LEN_MIN + 3'(wlen);
	endfunction

	function automatic logic parityBit(input logic [7:0] d,
	                                   input ufc_cfg_s   c);
		logic [7:0] m;
		m = d & (8'hff >> (`UFC_LEN_8 - c.wlen));
		case (c.pkind)
			`UFC_PAR_ODD:  parityBit = ~(^m);
			`UFC_PAR_EVEN: parityBit = ^m;
			`UFC_PAR_MARK: parityBit = 1'b1;
			default:       parityBit = 1'b0;
		endcase
	endfunction

	function automatic logic [2:0] stopHalves(input ufc_cfg_s c);
		if (!c.lstop) begin
			stopHalves = `UFC_HALF_BIT;
		end else if (c.wlen == `UFC_LEN_5) begin
			stopHalves = `UFC_HALF_1P5;
		end else begin
			stopHalves = `UFC_HALF_2;
		end
	endfunction

	// ------------------------------------------------------------
	// receive buffer
	// ------------------------------------------------------------
	assign popReq = sfrRd && (sfrAddr == `UFC_DATA_BUF_ADDR);

	ufc_fifo #(
		.WIDTH ($bits(ufc_rx_word_s)),
		.DEPTH (`UFC_FIFO_DEPTH)
	) u_rx_fifo (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.inValid  (s.pendValid),
		.inData   (s.pend),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (headWord),
		.outReady (popReq)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_s  = s;
		rxGood  = 1'b0;
		rxPerr  = s.cfg.pon && (s.rxPar != parityBit(s.rxShift, s.cfg));
		rxTick  = (s.rxCnt == HALF_LAST);
		rxEvent = rxTick && (s.rxHalf == 3'h1);
		txTick  = (s.txCnt == HALF_LAST);
		txEnd   = txTick && (s.txHalf == 3'h1);

		// sfr access
		if (sfrWr && sfrAddr == `UFC_FRAME_CTRL_ADDR) begin
			next_s.cfg = ufc_cfg_s'(sfrWrData);
		end
		if (sfrRd) begin
			case (sfrAddr)
				`UFC_FRAME_CTRL_ADDR: next_s.rdData = s.cfg;
				`UFC_DATA_BUF_ADDR:   next_s.rdData =
					fifoOutValid ? headWord.data : 8'h00;
				default:              next_s.rdData = 8'h00;
			endcase
		end

		// pin sync: first stage feeds only the second
		next_s.rxSync = {s.rxSync[1:0], rxPin};
		if (s.rxSync[1] == s.rxSync[2]) begin
			next_s.rxLevel = s.rxSync[2];
		end

		// receive bit timing
		if (s.rxSt != RX_IDLE && s.rxSt != RX_WAITHI) begin
			next_s.rxCnt = rxTick ? 16'h0000 : s.rxCnt + 16'h0001;
			if (rxTick && !rxEvent) begin
				next_s.rxHalf = s.rxHalf - 3'h1;
			end
		end
		if (rxEvent) begin
			next_s.rxHalf = `UFC_HALF_BIT;
		end

		case (s.rxSt)
			RX_IDLE: begin
				// a word still waiting for fifo room stalls reception
				if (!s.rxLevel && !s.pendValid) begin
					next_s.rxSt    = RX_START;
					next_s.rxCnt   = 16'h0000;
					next_s.rxHalf  = 3'h1;
					next_s.rxShift = 8'h00;
					next_s.rxXbit  = 1'b0;
					next_s.rxPar   = 1'b0;
				end
			end
			RX_START: begin
				if (rxEvent) begin
					next_s.rxIdx = 3'h0;
					next_s.rxSt  = s.rxLevel ? RX_WAITHI : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rxEvent) begin
					next_s.rxShift[s.rxIdx] = s.rxLevel;
					next_s.rxIdx            = s.rxIdx + 3'h1;
					if (s.rxIdx == lastIdx(s.cfg.wlen)) begin
						next_s.rxSt = s.cfg.pon ? RX_PAR :
							(s.cfg.xon ? RX_XTRA : RX_STOP);
					end
				end
			end
			RX_PAR: begin
				if (rxEvent) begin
					next_s.rxPar = s.rxLevel;
					next_s.rxSt  = s.cfg.xon ? RX_XTRA : RX_STOP;
				end
			end
			RX_XTRA: begin
				if (rxEvent) begin
					next_s.rxXbit = s.rxLevel;
					next_s.rxSt   = RX_STOP;
				end
			end
			RX_STOP: begin
				if (rxEvent) begin
					// without the extra bit, multiprocessor mode never matches
					rxGood = s.rxLevel && (!s.cfg.mce || s.rxXbit);
					next_s.rxSt = s.rxLevel ? RX_IDLE : RX_WAITHI;
				end
			end
			RX_WAITHI: begin
				if (s.rxLevel) begin
					next_s.rxSt = RX_IDLE;
				end
			end
			default: next_s.rxSt = RX_IDLE;
		endcase

		// hand-off into the fifo
		if (s.pendValid && fifoInReady) begin
			next_s.pendValid = 1'b0;
		end
		if (rxGood) begin
			next_s.pend      = '{xbit: s.rxXbit, perr: rxPerr,
			                     data: s.rxShift};
			next_s.pendValid = 1'b1;
			next_s.parErr    = rxPerr;
			next_s.lastXbit  = s.rxXbit;
		end

		// set beats clear; clear only with nothing left to read
		if (rxGood) begin
			next_s.doneFlag = 1'b1;
		end else if (rxDoneClear && !fifoOutValid && !s.pendValid) begin
			next_s.doneFlag = 1'b0;
		end

		// transmit bit timing
		if (s.txSt != TX_IDLE) begin
			next_s.txCnt = txTick ? 16'h0000 : s.txCnt + 16'h0001;
			if (txTick && !txEnd) begin
				next_s.txHalf = s.txHalf - 3'h1;
			end
		end
		if (txEnd) begin
			next_s.txHalf = `UFC_HALF_BIT;
		end

		case (s.txSt)
			TX_IDLE: begin
				// a write while busy is dropped, there is no tx queue
				if (sfrWr && sfrAddr == `UFC_DATA_BUF_ADDR) begin
					next_s.txSt    = TX_START;
					next_s.txShift = sfrWrData;
					next_s.txXbit  = txExtraBit;
					next_s.txCnt   = 16'h0000;
					next_s.txHalf  = `UFC_HALF_BIT;
					next_s.txLine  = 1'b0;
					next_s.txBusy  = 1'b1;
				end
			end
			TX_START: begin
				if (txEnd) begin
					next_s.txSt   = TX_DATA;
					next_s.txIdx  = 3'h0;
					next_s.txLine = s.txShift[0];
				end
			end
			TX_DATA: begin
				if (txEnd) begin
					next_s.txIdx = s.txIdx + 3'h1;
					if (s.txIdx != lastIdx(s.cfg.wlen)) begin
						next_s.txLine = s.txShift[s.txIdx + 3'h1];
					end else if (s.cfg.pon) begin
						next_s.txSt   = TX_PAR;
						next_s.txLine = parityBit(s.txShift, s.cfg);
					end else if (s.cfg.xon) begin
						next_s.txSt   = TX_XTRA;
						next_s.txLine = s.txXbit;
					end else begin
						next_s.txSt   = TX_STOP;
						next_s.txLine = 1'b1;
						next_s.txHalf = stopHalves(s.cfg);
					end
				end
			end
			TX_PAR: begin
				if (txEnd) begin
					if (s.cfg.xon) begin
						next_s.txSt   = TX_XTRA;
						next_s.txLine = s.txXbit;
					end else begin
						next_s.txSt   = TX_STOP;
						next_s.txLine = 1'b1;
						next_s.txHalf = stopHalves(s.cfg);
					end
				end
			end
			TX_XTRA: begin
				if (txEnd) begin
					next_s.txSt   = TX_STOP;
					next_s.txLine = 1'b1;
					next_s.txHalf = stopHalves(s.cfg);
				end
			end
			TX_STOP: begin
				if (txEnd) begin
					next_s.txSt   = TX_IDLE;
					next_s.txBusy = 1'b0;
				end
			end
			default: next_s.txSt = TX_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s         <= '0;
			s.cfg     <= ufc_cfg_s'(`UFC_FRAME_CTRL_RST);
			s.rxSync  <= 3'h7;
			s.rxLevel <= 1'b1;
			s.txLine  <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign sfrRdData   = s.rdData;
	assign txPin       = s.txLine;
	assign txBusy      = s.txBusy;
	assign rxDoneFlag  = s.doneFlag;
	assign rxExtraBit  = s.lastXbit;
	assign parityError = s.parErr;
endmodule

// ---- tb/ufc_serial_port_asserts.sv ----
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_serial_port_asserts
	import ufc_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic       sfrWr,
	input wire logic       rxDoneClear,
	input wire logic       rxPin,
	input wire logic       txPin,
	input wire logic       txBusy,
	input wire logic       rxDoneFlag,
	input wire logic       rxExtraBit,
	input wire logic       parityError
);
	localparam int BIT = 2 * `UFC_HALF_CYC;
	ufc_cfg_s cfg;
	int       ph;
	int       hi;
	int       stopLen;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ------
	// shadow of frame control; assumes no change mid-frame
	// ------
	assign stopLen = !cfg.lstop ? BIT :
		cfg.wlen == `UFC_LEN_5 ? BIT * 3 / 2 : BIT * 2;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg <= ufc_cfg_s'(`UFC_FRAME_CTRL_RST);
			ph  <= 0;
			hi  <= 0;
		end else begin
			if (sfrWr && sfrAddr == `UFC_FRAME_CTRL_ADDR)
				cfg <= ufc_cfg_s'(sfrWrData);
			ph <= (!txBusy || ph == BIT - 1) ? 0 : ph + 1;
			hi <= (txBusy && txPin) ? hi + 1 : 0;
		end
	end
	property p_idle; !txBusy |-> txPin; endproperty
	a_idle: assert property (p_idle)
		else $error("line not high when idle");
	property p_start; sfrWr && sfrAddr == `UFC_DATA_BUF_ADDR && !txBusy
		|=> txBusy && !txPin; endproperty
	a_start: assert property (p_start)
		else $error("no start bit after data write");
	property p_phase; txBusy && $changed(txPin) |-> ph == 0; endproperty
	a_phase: assert property (p_phase)
		else $error("bit edge off the bit grid");
	property p_stop; $fell(txBusy) |->
		hi >= stopLen && hi % BIT == stopLen % BIT; endproperty
	a_stop: assert property (p_stop)
		else $error("stop length wrong");
	property p_flag; $rose(rxDoneFlag) |-> rxPin; endproperty
	a_flag: assert property (p_flag)
		else $error("flag set without high stop");
	property p_hold; $fell(rxDoneFlag) |-> $past(rxDoneClear); endproperty
	a_hold: assert property (p_hold)
		else $error("flag dropped without clear");
	property p_mce; $rose(rxDoneFlag) && cfg.mce |-> rxExtraBit; endproperty
	a_mce: assert property (p_mce)
		else $error("flag set with extra bit low");
	property p_npar; $rose(rxDoneFlag) && !cfg.pon |-> !parityError;
	endproperty
	a_npar: assert property (p_npar)
		else $error("parity error with parity off");
endmodule
bind ufc_serial_port ufc_serial_port_asserts chk (.*);

// ---- tb/ufc_remote_xcvr.sv ----
`timescale 1ns/1ps
`include "ufc_defs.svh"
module ufc_remote_xcvr (
	input  wire logic       ref_clk,
	input  wire logic       txPin,
	input  wire logic [3:0] txLen,
	output logic            rxPin,
	output logic [11:0]     txWord,
	output logic            txSeen
);
	localparam int BIT = 2 * `UFC_HALF_CYC;
	// ------
	// line rests at mark; gap sets prompt or slow pacing
	// ------
	initial begin
		rxPin  = 1'b1;
		txSeen = 1'b0;
	end
	task automatic send(input logic [11:0] w, input logic [3:0] n,
		input int gap);
		rxPin <= 1'b0;
		repeat (BIT) @(negedge ref_clk);
		for (int i = 0; i < n; i++) begin
			rxPin <= w[i];
			repeat (BIT) @(negedge ref_clk);
		end
		rxPin <= 1'b1;
		repeat (gap) @(negedge ref_clk);
	endtask
	always begin
		@(negedge txPin);
		txWord <= '0;
		repeat (BIT / 2) @(posedge ref_clk);
		for (int i = 0; i < txLen; i++) begin
			repeat (BIT) @(posedge ref_clk);
			txWord[i] <= txPin;
		end
		@(posedge ref_clk) txSeen <= 1'b1;
		@(posedge ref_clk) txSeen <= 1'b0;
	end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "ufc_defs.svh"
module testbench;
	import ufc_pkg::*;
	logic        ref_clk, rst_b, sfrWr, sfrRd, rxDoneClear, txExtraBit;
	logic        rxPin, txPin, txBusy, rxDoneFlag, rxExtraBit, parityError;
	logic        txSeen, rdSeen;
	logic [7:0]  sfrAddr, sfrWrData, sfrRdData;
	logic [3:0]  txLen;
	logic [11:0] txWord;
	logic [11:0] expTx[$];
	logic [7:0]  expRd[$];
	int          errors, total_checks, cycleCount;
	int          seed = 32'h665aaf33;
	ufc_serial_port dut (.ref_clk(ref_clk), .rst_b(rst_b), .sfrAddr(sfrAddr),
		.sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd),
		.sfrRdData(sfrRdData), .rxDoneClear(rxDoneClear),
		.txExtraBit(txExtraBit), .rxPin(rxPin), .txPin(txPin),
		.txBusy(txBusy), .rxDoneFlag(rxDoneFlag), .rxExtraBit(rxExtraBit),
		.parityError(parityError));
	ufc_remote_xcvr far (.ref_clk(ref_clk), .txPin(txPin), .txLen(txLen),
		.rxPin(rxPin), .txWord(txWord), .txSeen(txSeen));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ------
	// bus tasks, frame model and compare
	// ------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		sfrWr     = wr;
		sfrRd     = !wr;
		sfrAddr   = a;
		sfrWrData = d;
		@(negedge ref_clk);
		sfrWr = 1'b0;
		sfrRd = 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expRd.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask
	task automatic clr();
		rxDoneClear = 1'b1;
		@(negedge ref_clk);
		rxDoneClear = 1'b0;
		@(negedge ref_clk);
	endtask
	task automatic flags(input logic [2:0] e);
		chk({9'h0, rxDoneFlag, parityError, rxExtraBit}, {9'h0, e});
	endtask
	function automatic logic [11:0] mk(input logic [7:0] d, input ufc_cfg_s c,
		input logic x, output logic [3:0] n);
		logic [11:0] w;
		n = {2'h0, c.wlen} + 4'h5;
		w = {4'h0, d} & ((12'h1 << n) - 12'h1);
		if (c.pon) begin
			w[n] = c.pkind[1] ? !c.pkind[0] : (^w) ^ !c.pkind[0];
			n = n + 4'h1;
		end
		if (c.xon) begin
			w[n] = x;
			n = n + 4'h1;
		end
		w[n] = 1'b1;
		n = n + 4'h1;
		return w;
	endfunction
	task automatic print_verdict();
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge ref_clk) rdSeen <= sfrRd;
	always @(negedge ref_clk) if (rdSeen)
		chk({4'h0, sfrRdData}, {4'h0, expRd.pop_front()});
	always @(posedge txSeen)
		chk(txWord, expTx.pop_front());
	always @(posedge ref_clk) begin
		cycleCount++;
		if (cycleCount == 90000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		ufc_cfg_s    c;
		logic [7:0]  d;
		logic [11:0] w;
		logic [3:0]  n;
		{sfrWr, sfrRd, rxDoneClear, txExtraBit, rst_b} = '0;
		{sfrAddr, sfrWrData} = '0;
		txLen = 4'hc;
		repeat (4) @(negedge ref_clk);
		rst_b = 1'b1;
		@(negedge ref_clk);
		rd(`UFC_FRAME_CTRL_ADDR, `UFC_FRAME_CTRL_RST);
		rd(8'ha5, 8'h00);
		// every length, parity kind and stop choice; 5-bit long gives 1.5
		for (int k = 0; k < 5; k++) begin
			c = ufc_cfg_s'(8'h00);
			c.pkind = k[1:0];
			c.pon = k < 4;
			c.wlen = k[1:0];
			c.xon = k[1];
			c.lstop = !k[0];
			d = $random(seed);
			txExtraBit = $random(seed);
			acc(1'b1, `UFC_FRAME_CTRL_ADDR, c);
			rd(`UFC_FRAME_CTRL_ADDR, c);
			expTx.push_back(mk(d, c, txExtraBit, txLen));
			acc(1'b1, `UFC_DATA_BUF_ADDR, d);
			acc(1'b1, `UFC_DATA_BUF_ADDR, ~d);
			for (int i = 0; i < 8000 && txBusy; i++)
				@(negedge ref_clk);
		end
		c = ufc_cfg_s'(8'h3e);
		acc(1'b1, `UFC_FRAME_CTRL_ADDR, c);
		d = $random(seed);
		w = mk(d, c, 1'b0, n);
		far.send(w, n, 2);
		w = mk(~d, c, 1'b1, n);
		far.send(w ^ 12'h100, n, 300);
		flags(3'h7);
		clr();
		flags(3'h7);
		rd(`UFC_DATA_BUF_ADDR, d);
		rd(`UFC_DATA_BUF_ADDR, ~d);
		rd(`UFC_DATA_BUF_ADDR, 8'h00);
		clr();
		flags(3'h3);
		c = ufc_cfg_s'(8'h8e);
		acc(1'b1, `UFC_FRAME_CTRL_ADDR, c);
		w = mk(~d, c, 1'b0, n);
		far.send(w, n, 20);
		flags(3'h3);
		w = mk(d, c, 1'b1, n);
		far.send(w, n, 20);
		flags(3'h5);
		rd(`UFC_DATA_BUF_ADDR, d);
		chk(12'(expTx.size()), 12'h0);
		print_verdict();
	end
endmodule
